// *** hw/motion_irq_dev.sv ***
// Sensor end: interrupt status, latching, pin drive, offset compensation
// and the 96-sample buffer (32 three-axis frames) behind a byte register port.
// Assumes detector hits and samples arrive on i_clk from on-chip logic.
`timescale 1ns/10ps
`default_nettype none
`include "motion_irq_params.svh"
// Function
// - Each source enabled alone sets status, pin
// - Pin is OR of mapped interrupts
// - Motion events OR enabled axis detections
// - Latch code selects non-latched, latched, temporary
// - Temporary mode clears after selected hold
// - Non-latched clears when condition ends
// - Latched clears on reset bit, reasserts
// - Source bit picks filtered or unfiltered data
// - Other statuses fixed: new-data 250us, levels
// - Route bits map each interrupt per pin
// - Pins configurable drive and polarity
// - Add scaled two's complement axis offsets
// - Offset clear bit zeroes all offsets
// - Host updates offsets after new-data interrupt
// - Buffer holds 32 frames or 96 samples
// - Bypass keeps one frame, overwrite sets overrun
// - FIFO mode stops when full
// - Stream mode drops oldest, sets overrun
// - Stream-to-FIFO switches on motion interrupt
// - Bypass-to-stream switches on motion interrupt
// - Switch only when event routed to pin A
// - Three-bit mode field encodes buffer modes
// - Config write clears buffer and level statuses
// - Level reported; overrun clears on read
module motion_irq_dev #(
  parameter int TICK_CYC = `CLK_HZ / `HZ_PER_MHZ
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  motion_irq_if.dev bus,
  input wire logic i_sample_valid,
  input wire motion_irq_pkg::sample_t i_filt_x,
  input wire motion_irq_pkg::sample_t i_filt_y,
  input wire motion_irq_pkg::sample_t i_filt_z,
  input wire motion_irq_pkg::sample_t i_raw_x,
  input wire motion_irq_pkg::sample_t i_raw_y,
  input wire motion_irq_pkg::sample_t i_raw_z,
  input wire motion_irq_pkg::axis_vec_t i_slope_hit_filt,
  input wire motion_irq_pkg::axis_vec_t i_slope_hit_raw,
  input wire motion_irq_pkg::axis_vec_t i_major_hit_filt,
  input wire motion_irq_pkg::axis_vec_t i_major_hit_raw,
  input wire logic [3:0] i_range,
  output logic o_acc_valid,
  output motion_irq_pkg::sample_t o_acc_x,
  output motion_irq_pkg::sample_t o_acc_y,
  output motion_irq_pkg::sample_t o_acc_z
);
  import motion_irq_pkg::*;

  reg_byte_t path_q, axis_en_q, ev_en_q, route_a_q, route_b_q, pin_cfg_q;
  reg_byte_t major_q, bcfg_a_q, bcfg_b_q, rdata_q;
  logic [3:0] hold_q;
  logic [2:0][7:0] ofs_q;
  logic [2:0][11:0] acc_q;
  logic acc_valid_q;

  wire wr_hold = bus.wr && bus.addr == `ADDR_HOLD_CFG;
  wire irq_rst = wr_hold && bus.wdata[`HOLD_RST_BIT];
  wire ofs_clr = bus.wr && bus.addr == `ADDR_OFS_CTRL &&
    bus.wdata[`OFS_CLR_BIT];
  wire cfg_wr = bus.wr && (bus.addr == `ADDR_BUF_CFG_A ||
    bus.addr == `ADDR_BUF_CFG_B);
  wire is_ofs = bus.addr >= `ADDR_OFS_X && bus.addr <= `ADDR_OFS_Z;
  wire [1:0] ofs_idx = 2'(bus.addr - `ADDR_OFS_X);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      path_q <= `RST_BYTE;
      axis_en_q <= `RST_BYTE;
      ev_en_q <= `RST_BYTE;
      route_a_q <= `RST_BYTE;
      route_b_q <= `RST_BYTE;
      pin_cfg_q <= `RST_BYTE;
      major_q <= `RST_BYTE;
      bcfg_a_q <= `RST_BYTE;
      bcfg_b_q <= `RST_BYTE;
      hold_q <= 4'h0;
    end else if (bus.wr) begin
      case (bus.addr)
        `ADDR_PATH_CFG: path_q <= bus.wdata;
        `ADDR_AXIS_EN: axis_en_q <= bus.wdata;
        `ADDR_EVENT_EN: ev_en_q <= bus.wdata;
        `ADDR_ROUTE_A: route_a_q <= bus.wdata;
        `ADDR_ROUTE_B: route_b_q <= bus.wdata;
        `ADDR_PIN_CFG: pin_cfg_q <= bus.wdata;
        `ADDR_MAJOR_CFG: major_q <= bus.wdata;
        `ADDR_BUF_CFG_A: bcfg_a_q <= bus.wdata;
        `ADDR_BUF_CFG_B: bcfg_b_q <= bus.wdata;
        `ADDR_HOLD_CFG: hold_q <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  // Offsets: clear and write never share an address
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) ofs_q <= '0;
    else if (ofs_clr) ofs_q <= '0;
    else if (bus.wr && is_ofs) ofs_q[ofs_idx] <= bus.wdata;
  end

  // Microsecond tick keeps hold counters short
  logic [11:0] tick_q;
  wire us_tick = tick_q == 12'(TICK_CYC - 1);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) tick_q <= 12'h0;
    else tick_q <= us_tick ? 12'h0 : tick_q + 12'h1;
  end

  wire eng_raw = path_q[`PATH_ENG_RAW_BIT];
  wire [2:0] slope_hit = eng_raw ? i_slope_hit_raw : i_slope_hit_filt;
  wire [2:0] major_hit = eng_raw ? i_major_hit_raw : i_major_hit_filt;
  wire [2:0] slope_axes = slope_hit & axis_en_q[2:0];
  wire any_cond = major_q[`MAJ_ANY_EN_BIT] && |slope_axes;
  wire sig_cond = major_q[`MAJ_SIG_EN_BIT] &&
    |(major_hit & axis_en_q[2:0]);
  wire [1:0] mot_cond = {sig_cond, any_cond};
  wire mode_none = hold_q[2:0] == `LATCH_NONE_LOW;
  wire mode_latch = hold_q[2:0] == `LATCH_HOLD_LOW;

  function automatic logic [23:0] hold_time(input logic [3:0] c);
    case (c)
      4'h1: hold_time = 24'(`T_250MS_US);
      4'h2: hold_time = 24'(`T_500MS_US);
      4'h3: hold_time = 24'(`T_1S_US);
      4'h4: hold_time = 24'(`T_2S_US);
      4'h5: hold_time = 24'(`T_4S_US);
      4'h6: hold_time = 24'(`T_8S_US);
      4'h9: hold_time = 24'(`T_250US_US);
      4'ha: hold_time = 24'(`T_500US_US);
      4'hb: hold_time = 24'(`T_1MS_US);
      4'hc: hold_time = 24'(`T_12MS5_US);
      4'hd: hold_time = 24'(`T_25MS_US);
      4'he: hold_time = 24'(`T_50MS_US);
      default: hold_time = 24'h1;
    endcase
  endfunction
  wire [23:0] hold_us = hold_time(hold_q);

  logic [1:0] mot_sts;
  for (genvar m = 0; m < 2; m++) begin : g_mot
    logic sts_q;
    logic [23:0] left_q;
    wire expire = sts_q && us_tick && left_q <= 24'h1;
    wire load = mot_cond[m] && (!sts_q || expire);
    wire temp_d = load || (sts_q && !expire);
    wire latch_d = mot_cond[m] || (sts_q && !irq_rst);
    wire sts_d = mode_none ? mot_cond[m] :
      mode_latch ? latch_d : temp_d;
    assign mot_sts[m] = sts_q;
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        sts_q <= 1'b0;
        left_q <= 24'h0;
      end else begin
        sts_q <= sts_d;
        if (load) left_q <= hold_us;
        else if (us_tick && left_q != 24'h0) left_q <= left_q - 24'h1;
      end
    end
  end

  // Axes that raised the first any-motion assertion
  logic [2:0] first_q;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) first_q <= 3'h0;
    else if (any_cond && !mot_sts[`SRC_ANY]) first_q <= slope_axes;
  end

  // New-data status self-clears; a fresh sample reloads (set wins)
  logic nd_q;
  logic [8:0] nd_left_q;
  wire nd_set = i_sample_valid && ev_en_q[`EV_NEW_BIT];
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nd_q <= 1'b0;
      nd_left_q <= 9'h0;
    end else if (nd_set) begin
      nd_q <= 1'b1;
      nd_left_q <= 9'(`T_NEW_US);
    end else if (!ev_en_q[`EV_NEW_BIT]) begin
      nd_q <= 1'b0;
    end else if (us_tick && nd_q) begin
      nd_left_q <= nd_left_q - 9'h1;
      if (nd_left_q <= 9'h1) nd_q <= 1'b0;
    end
  end

  // Offset compensation, one step is 7.81 mg in every range
  wire [1:0] ofs_sh = i_range == 4'h3 ? 2'd3 : i_range == 4'h5 ? 2'd2 : 2'd1;
  wire out_raw = path_q[`PATH_OUT_RAW_BIT];
  wire [2:0][11:0] raw_v = {i_raw_z, i_raw_y, i_raw_x};
  wire [2:0][11:0] filt_v = {i_filt_z, i_filt_y, i_filt_x};
  logic [2:0][11:0] comp_v;
  for (genvar a = 0; a < 3; a++) begin : g_axis
    wire [11:0] ext = {{4{ofs_q[a][7]}}, ofs_q[a]} << ofs_sh;
    assign comp_v[a] = (out_raw ? raw_v[a] : filt_v[a]) + ext;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q <= '0;
      acc_valid_q <= 1'b0;
    end else begin
      acc_valid_q <= i_sample_valid;
      if (i_sample_valid) acc_q <= comp_v;
    end
  end

  // Sample buffer: pointers count samples, level counts frames
  logic [6:0] level_q, rp_q, wp_q;
  logic [2:0] bcnt_q;
  logic ovr_q, trig_q;
  logic [11:0] mem_q [`BUF_SAMPLES];
  wire [2:0] bmode = bcfg_b_q[`BUF_MODE_MSB:`BUF_MODE_LSB];
  wire xyz = bcfg_b_q[1:0] == 2'b00;
  wire [6:0] fsz = xyz ? 7'd3 : 7'd1;
  wire trig_ev = |(mot_sts & route_a_q[1:0]);
  buf_mode_t eff;
  assign eff = bmode == BUF_STREAM_FIFO ?
      (trig_q ? BUF_FIFO : BUF_STREAM) :
    bmode == BUF_BYPASS_STREAM ?
      (trig_q ? BUF_STREAM : BUF_BYPASS) :
    bmode == BUF_FIFO ? BUF_FIFO :
    bmode == BUF_STREAM ? BUF_STREAM : BUF_BYPASS;
  wire [6:0] cap = eff == BUF_BYPASS ? 7'd1 :
    xyz ? 7'(`BUF_FRAMES) : 7'(`BUF_SAMPLES);
  wire full = level_q == cap;
  wire rd_data = bus.rd && bus.addr == `ADDR_BUF_DATA;
  wire last_byte = bcnt_q == (xyz ? 3'd5 : 3'd1);
  // A frame left half read is dropped at the next read of another address
  wire pop = level_q != 7'h0 && ((rd_data && last_byte) ||
    (bus.rd && !rd_data && bcnt_q != 3'h0));
  wire push = i_sample_valid && !(eff == BUF_FIFO && full && !pop);
  wire drop = push && full && !pop;

  function automatic logic [6:0] wrap(input logic [6:0] p,
      input logic [6:0] n);
    logic [7:0] s;
    s = {1'b0, p} + {1'b0, n};
    wrap = s >= 8'(`BUF_SAMPLES) ? 7'(s - 8'(`BUF_SAMPLES)) : s[6:0];
  endfunction
  wire [6:0] wp1 = wrap(wp_q, 7'd1);
  wire [6:0] wp2 = wrap(wp_q, 7'd2);
  wire [1:0] one_ax = bcfg_b_q[1:0] - 2'd1;
  wire [11:0] one_v = comp_v[one_ax];

  for (genvar e = 0; e < `BUF_SAMPLES; e++) begin : g_mem
    always_ff @(posedge i_clk) begin
      if (push && e == wp_q) mem_q[e] <= xyz ? comp_v[0] : one_v;
      else if (push && xyz && e == wp1) mem_q[e] <= comp_v[1];
      else if (push && xyz && e == wp2) mem_q[e] <= comp_v[2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_q <= 7'h0;
      rp_q <= 7'h0;
      wp_q <= 7'h0;
      ovr_q <= 1'b0;
      bcnt_q <= 3'h0;
    end else if (cfg_wr) begin
      level_q <= 7'h0;
      rp_q <= 7'h0;
      wp_q <= 7'h0;
      ovr_q <= 1'b0;
      bcnt_q <= 3'h0;
    end else begin
      if (pop || drop) rp_q <= wrap(rp_q, fsz);
      if (push) wp_q <= wrap(wp_q, fsz);
      level_q <= level_q + 7'(push) - 7'(pop) - 7'(drop);
      ovr_q <= (i_sample_valid && full) || (ovr_q && !pop);
      if (pop || (bus.rd && !rd_data)) bcnt_q <= 3'h0;
      else if (rd_data && level_q != 7'h0) bcnt_q <= bcnt_q + 3'h1;
    end
  end

  // Trigger holds until the buffer is reconfigured; set wins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) trig_q <= 1'b0;
    else trig_q <= trig_ev || (trig_q && !cfg_wr);
  end

  wire [6:0] wm_lvl = bcfg_a_q[6:0];
  wire wm_sts = ev_en_q[`EV_WM_BIT] && wm_lvl != 7'h0 &&
    level_q >= wm_lvl;
  wire full_sts = ev_en_q[`EV_FULL_BIT] && full;
  wire [4:0] src = {full_sts, wm_sts, nd_q, mot_sts};

  wire [11:0] rd_smp = mem_q[wrap(rp_q, {5'h0, bcnt_q[2:1]})];
  wire [7:0] buf_byte = level_q == 7'h0 ? 8'h00 :
    bcnt_q[0] ? rd_smp[11:4] : {rd_smp[3:0], 4'h0};

  reg_byte_t rd_mux;
  always_comb begin
    case (bus.addr)
      `ADDR_MOTION_STS: rd_mux = {5'h0, mot_sts[`SRC_ANY], 1'b0,
        mot_sts[`SRC_SIG]};
      `ADDR_EVENT_STS: rd_mux = {nd_q, wm_sts, full_sts, 5'h0};
      `ADDR_SLOPE_FIRST: rd_mux = {5'h0, first_q};
      `ADDR_BUF_LEVEL: rd_mux = {ovr_q, level_q};
      `ADDR_PATH_CFG: rd_mux = path_q;
      `ADDR_AXIS_EN: rd_mux = axis_en_q;
      `ADDR_EVENT_EN: rd_mux = ev_en_q;
      `ADDR_ROUTE_A: rd_mux = route_a_q;
      `ADDR_ROUTE_B: rd_mux = route_b_q;
      `ADDR_PIN_CFG: rd_mux = pin_cfg_q;
      `ADDR_HOLD_CFG: rd_mux = {4'h0, hold_q};
      `ADDR_MAJOR_CFG: rd_mux = major_q;
      `ADDR_OFS_X: rd_mux = ofs_q[0];
      `ADDR_OFS_Y: rd_mux = ofs_q[1];
      `ADDR_OFS_Z: rd_mux = ofs_q[2];
      `ADDR_BUF_CFG_A: rd_mux = bcfg_a_q;
      `ADDR_BUF_CFG_B: rd_mux = bcfg_b_q;
      `ADDR_BUF_DATA: rd_mux = buf_byte;
      default: rd_mux = 8'h00;
    endcase
  end

  // Pin drive: open drain can only pull low, release floats high
  logic [1:0] pin_o_q, pin_oe_q;
  wire [1:0][7:0] route_v = {route_b_q, route_a_q};
  for (genvar p = 0; p < 2; p++) begin : g_pin
    wire act = |(src & route_v[p][4:0]);
    wire lvl = pin_cfg_q[2*p+`PIN_HIGH_BIT] ? act : !act;
    wire od = pin_cfg_q[2*p+`PIN_OD_BIT];
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        pin_o_q[p] <= 1'b0;
        pin_oe_q[p] <= 1'b0;
      end else begin
        pin_o_q[p] <= od ? 1'b0 : lvl;
        pin_oe_q[p] <= od ? !lvl : 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) rdata_q <= 8'h00;
    else rdata_q <= bus.rd ? rd_mux : 8'h00;
  end

  assign bus.rdata = rdata_q;
  assign bus.irq_a_o = pin_o_q[0];
  assign bus.irq_a_oe = pin_oe_q[0];
  assign bus.irq_b_o = pin_o_q[1];
  assign bus.irq_b_oe = pin_oe_q[1];
  assign o_acc_valid = acc_valid_q;
  assign o_acc_x = acc_q[0];
  assign o_acc_y = acc_q[1];
  assign o_acc_z = acc_q[2];
endmodule
`default_nettype wire

// *** hw/motion_irq_host.sv ***
// Host end: turns user commands into register strobes, watches the
// interrupt pins, acknowledges latched interrupts.
// Assumes new-data is routed to pin A when offset writes are deferred.
`timescale 1ns/10ps
`default_nettype none
`include "motion_irq_params.svh"
module motion_irq_host (
  input wire logic i_clk,
  input wire logic i_rstn,
  motion_irq_if.host bus,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire motion_irq_pkg::reg_byte_t i_cmd_addr,
  input wire motion_irq_pkg::reg_byte_t i_cmd_wdata,
  input wire logic i_irq_ack,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output motion_irq_pkg::reg_byte_t o_rsp_data,
  output logic o_irq_a,
  output logic o_irq_b
);
  import motion_irq_pkg::*;

  host_state_t state_q, state_d;
  logic [1:0] s1_q, s2_q, s3_q, pin_q, act_q;
  logic wr_q, rd_q, rd_d1_q, ack_pend_q, rsp_valid_q;
  reg_byte_t addr_q, wdata_q, pend_addr_q, pend_data_q, rsp_q;
  logic [3:0] hold_sh_q;
  logic [3:0] pin_sh_q;

  // Pin changes count once stages two and three agree
  wire [1:0] agree = ~(s2_q ^ s3_q);
  wire [1:0] pin_d = (agree & s2_q) | (~agree & pin_q);
  wire [1:0] pol = {pin_sh_q[2+`PIN_HIGH_BIT], pin_sh_q[`PIN_HIGH_BIT]};
  wire [1:0] act = ~(pin_q ^ pol);
  wire nd_rise = act[0] && !act_q[0];

  wire take = state_q == H_IDLE && i_cmd_valid && o_cmd_ready;
  wire cmd_ofs = i_cmd_addr >= `ADDR_OFS_X && i_cmd_addr <= `ADDR_OFS_Z;
  wire [2:0] cmd_mode = i_cmd_wdata[`BUF_MODE_MSB:`BUF_MODE_LSB];
  wire cmd_trig = i_cmd_addr == `ADDR_BUF_CFG_B &&
    (cmd_mode == BUF_STREAM_FIFO || cmd_mode == BUF_BYPASS_STREAM);
  wire defer = take && i_cmd_write && cmd_ofs;
  wire serve_ack = state_q == H_IDLE && !take && ack_pend_q;
  wire fire_ofs = state_q == H_OFS_WAIT && nd_rise;
  wire fix = state_q == H_LATCH_FIX;
  wire [7:0] latched = {4'h0, hold_sh_q[3], `LATCH_HOLD_LOW};

  always_comb begin
    case (state_q)
      H_IDLE: state_d = defer ? H_OFS_WAIT :
        (take && i_cmd_write && cmd_trig) ? H_LATCH_FIX : H_IDLE;
      H_OFS_WAIT: state_d = fire_ofs ? H_IDLE : H_OFS_WAIT;
      H_LATCH_FIX: state_d = H_IDLE;
      default: state_d = H_IDLE;
    endcase
  end

  wire wr_d = (take && i_cmd_write && !cmd_ofs) || serve_ack ||
    fire_ofs || fix;
  wire rd_d = take && !i_cmd_write;
  wire [7:0] addr_d = fire_ofs ? pend_addr_q :
    (serve_ack || fix) ? `ADDR_HOLD_CFG : i_cmd_addr;
  wire [7:0] wdata_d = fire_ofs ? pend_data_q :
    serve_ack ? {1'b1, 3'h0, hold_sh_q} :
    fix ? latched : i_cmd_wdata;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // Released pins read high; a low start would fake an edge
      s1_q <= 2'h3;
      s2_q <= 2'h3;
      s3_q <= 2'h3;
      pin_q <= 2'h3;
      act_q <= 2'h0;
    end else begin
      s1_q <= {bus.irq_pin_b, bus.irq_pin_a};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= pin_d;
      act_q <= act;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= H_IDLE;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rd_d1_q <= 1'b0;
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      pend_addr_q <= 8'h00;
      pend_data_q <= 8'h00;
      ack_pend_q <= 1'b0;
      hold_sh_q <= 4'h0;
      pin_sh_q <= 4'h0;
      o_cmd_ready <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_q <= 8'h00;
    end else begin
      state_q <= state_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      rd_d1_q <= rd_q;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      if (defer) pend_addr_q <= i_cmd_addr;
      if (defer) pend_data_q <= i_cmd_wdata;
      ack_pend_q <= i_irq_ack || (ack_pend_q && !serve_ack);
      if (wr_d && addr_d == `ADDR_HOLD_CFG) hold_sh_q <= wdata_d[3:0];
      if (wr_d && addr_d == `ADDR_PIN_CFG) pin_sh_q <= wdata_d[3:0];
      o_cmd_ready <= state_d == H_IDLE && !(state_q == H_IDLE && take &&
        i_cmd_write && cmd_trig);
      rsp_valid_q <= rd_d1_q;
      rsp_q <= rd_d1_q ? bus.rdata : 8'h00;
    end
  end

  assign bus.wr = wr_q;
  assign bus.rd = rd_q;
  assign bus.addr = addr_q;
  assign bus.wdata = wdata_q;
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_q;
  assign o_irq_a = act_q[0];
  assign o_irq_b = act_q[1];
endmodule
`default_nettype wire

// *** hw/motion_irq_if.sv ***
// Link between the sensor end and the host end: register port and two
// interrupt pins. Pins resolve here; an undriven pin reads high (pull-up).
`timescale 1ns/10ps
`default_nettype none
interface motion_irq_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq_a_o;
  logic irq_a_oe;
  logic irq_b_o;
  logic irq_b_oe;
  logic irq_pin_a;
  logic irq_pin_b;
  assign irq_pin_a = irq_a_oe ? irq_a_o : 1'b1;
  assign irq_pin_b = irq_b_oe ? irq_b_o : 1'b1;
  modport dev (
    input addr, wdata, wr, rd,
    output rdata, irq_a_o, irq_a_oe, irq_b_o, irq_b_oe
  );
  modport host (
    output addr, wdata, wr, rd,
    input rdata, irq_pin_a, irq_pin_b
  );
endinterface
`default_nettype wire

// *** hw/motion_irq_params.svh ***
// Register map, field positions, reset values and timing of the
// motion interrupt and sample buffer block.
// Assumes a 25 MHz clock and byte-wide registers at their printed offsets.
`ifndef MOTION_IRQ_PARAMS_SVH
`define MOTION_IRQ_PARAMS_SVH
`define ADDR_MOTION_STS 8'h09
`define ADDR_EVENT_STS 8'h0a
`define ADDR_SLOPE_FIRST 8'h0b
`define ADDR_BUF_LEVEL 8'h0c
`define ADDR_PATH_CFG 8'h13
`define ADDR_AXIS_EN 8'h16
`define ADDR_EVENT_EN 8'h17
`define ADDR_ROUTE_A 8'h19
`define ADDR_ROUTE_B 8'h1a
`define ADDR_PIN_CFG 8'h20
`define ADDR_HOLD_CFG 8'h21
`define ADDR_MAJOR_CFG 8'h2a
`define ADDR_OFS_CTRL 8'h36
`define ADDR_OFS_X 8'h38
`define ADDR_OFS_Y 8'h39
`define ADDR_OFS_Z 8'h3a
`define ADDR_BUF_CFG_A 8'h3d
`define ADDR_BUF_CFG_B 8'h3e
`define ADDR_BUF_DATA 8'h3f
`define RST_BYTE 8'h00
`define PATH_OUT_RAW_BIT 0
`define PATH_ENG_RAW_BIT 1
`define MAJ_SIG_EN_BIT 0
`define MAJ_ANY_EN_BIT 1
`define MS_SIG_BIT 0
`define MS_ANY_BIT 2
`define EV_FULL_BIT 5
`define EV_WM_BIT 6
`define EV_NEW_BIT 7
`define HOLD_RST_BIT 7
`define OFS_CLR_BIT 7
`define PIN_HIGH_BIT 0
`define PIN_OD_BIT 1
`define BUF_MODE_MSB 7
`define BUF_MODE_LSB 5
`define SRC_ANY 0
`define SRC_SIG 1
`define SRC_NEW 2
`define SRC_WM 3
`define SRC_FULL 4
`define LATCH_HOLD_LOW 3'b111
`define LATCH_NONE_LOW 3'b000
`define BUF_FRAMES 32
`define BUF_SAMPLES 96
`define CLK_HZ 25000000
`define HZ_PER_MHZ 1000000
`define T_NEW_US 250
`define T_250MS_US 250000
`define T_500MS_US 500000
`define T_1S_US 1000000
`define T_2S_US 2000000
`define T_4S_US 4000000
`define T_8S_US 8000000
`define T_250US_US 250
`define T_500US_US 500
`define T_1MS_US 1000
`define T_12MS5_US 12500
`define T_25MS_US 25000
`define T_50MS_US 50000
`endif

// *** hw/motion_irq_pkg.sv ***
// Types shared by both ends of the motion interrupt link.
// Constants live in motion_irq_params.svh.
package motion_irq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [11:0] sample_t;
  typedef logic [2:0] axis_vec_t;
  typedef enum logic [2:0] {
    BUF_BYPASS = 3'b000,
    BUF_FIFO = 3'b001,
    BUF_STREAM_FIFO = 3'b011,
    BUF_BYPASS_STREAM = 3'b100,
    BUF_STREAM = 3'b110
  } buf_mode_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_OFS_WAIT = 3'b010,
    H_LATCH_FIX = 3'b100
  } host_state_t;
endpackage

// *** testbench/motion_irq_props.sv ***
// Checker on the link between sensor end and host end.
// Assumes one clock domain; sees interface signals only.
`timescale 1ns/10ps
`default_nettype none
module motion_irq_props (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq_a_o,
  input wire logic irq_a_oe
);
  logic rd_q;
  logic [7:0] ra_q;
  logic [3:0] pcfg_q;
  logic [1:0] pcnt_q;
  wire logic pcfg_wr = wr && addr == 8'h20;
  wire logic pin_set = pcnt_q == 2'h3;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
    end else begin
      rd_q <= rd;
      ra_q <= addr;
    end
  end
  // Pins lag a config write by two flops; settle before judging
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pcfg_q <= 4'h0;
      pcnt_q <= 2'h0;
    end else if (pcfg_wr) begin
      pcfg_q <= wdata[3:0];
      pcnt_q <= 2'h0;
    end else if (!pin_set) begin
      pcnt_q <= pcnt_q + 2'h1;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_idle; !rd_q |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_unmap; rd_q && ra_q == 8'h01 |-> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_act; rd_q && (ra_q == 8'h21 || ra_q == 8'h36) |-> !rdata[7];
  endproperty
  a_act: assert property (p_act) else $error("action bit read");
  property p_lvl; rd_q && ra_q == 8'h0c |-> rdata[6:0] <= 7'h60; endproperty
  a_lvl: assert property (p_lvl) else $error("level too big");
  property p_ev; rd_q && ra_q == 8'h0a |-> rdata[4:0] == 5'h00; endproperty
  a_ev: assert property (p_ev) else $error("event spare bits");
  property p_mo; rd_q && ra_q == 8'h09 |-> rdata[7:3] == 5'h00; endproperty
  a_mo: assert property (p_mo) else $error("motion spare bits");
  property p_pp; pin_set && !pcfg_q[1] |-> irq_a_oe [*2]; endproperty
  a_pp: assert property (p_pp) else $error("push-pull not driving");
  property p_od; pin_set && pcfg_q[1] && irq_a_oe |-> !irq_a_o; endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
endmodule
`default_nettype wire

// *** testbench/tb_motion_interrupt_fifo_ctrl.sv ***
// Bench joining host end and sensor end over the link.
// Assumes host answers reads three edges after a command is taken.
`timescale 1ns/10ps
`default_nettype none
module tb_motion_interrupt_fifo_ctrl;
  import motion_irq_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic sv = 1'b0, cv = 1'b0, cw = 1'b0, ack = 1'b0;
  logic rdy, rv, ia, ib;
  reg_byte_t ca = 8'h00, cd = 8'h00, rdat;
  sample_t sx = 12'h000, sy = 12'h000, sz = 12'h000, ax;
  axis_vec_t hf = 3'h0, hr = 3'h0;
  reg_byte_t expq[$];
  logic [35:0] fr[0:63];
  logic [15:0] lf = 16'hf81c;
  reg_byte_t mc[3] = '{8'hc0, 8'h20, 8'h00};
  reg_byte_t lv[3] = '{8'ha0, 8'ha0, 8'h81};
  int np[3] = '{34, 34, 2};
  int ff[3] = '{2, 0, 1};
  int failures = 0, compares = 0, nf = 0, cyc = 0;
  always #20 i_clk = ~i_clk;
  motion_irq_if link();
  motion_irq_dev #(.TICK_CYC(1)) motion_irq_dev_inst (.i_clk(i_clk),
    .i_rstn(i_rstn), .bus(link), .i_sample_valid(sv), .i_filt_x(sx),
    .i_filt_y(sy), .i_filt_z(sz), .i_raw_x(~sx), .i_raw_y(~sy),
    .i_raw_z(~sz), .i_slope_hit_filt(hf), .i_slope_hit_raw(hr),
    .i_major_hit_filt(hf), .i_major_hit_raw(hr), .i_range(4'h3),
    .o_acc_valid(), .o_acc_x(ax), .o_acc_y(), .o_acc_z());
  motion_irq_host motion_irq_host_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .bus(link), .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_addr(ca),
    .i_cmd_wdata(cd), .i_irq_ack(ack), .o_cmd_ready(rdy),
    .o_rsp_valid(rv), .o_rsp_data(rdat), .o_irq_a(ia), .o_irq_b(ib));
  motion_irq_props motion_irq_props_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd),
    .rdata(link.rdata), .irq_a_o(link.irq_a_o), .irq_a_oe(link.irq_a_oe));
  function automatic logic [15:0] step(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input string n, input reg_byte_t s, input reg_byte_t e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Gap cycle after each command keeps cv from double assignment
  task automatic cmd(input logic w, input reg_byte_t a, input reg_byte_t d);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    @(posedge i_clk);
    while (rdy !== 1'b1) @(posedge i_clk);
    cv <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    cmd(1'b1, a, d);
  endtask
  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    expq.push_back(e);
    cmd(1'b0, a, 8'h00);
  endtask
  task automatic push(input int n);
    repeat (n) begin
      lf = step(lf);
      sx <= lf[11:0];
      sy <= lf[15:4];
      sz <= {lf[7:0], lf[15:12]};
      fr[nf] = {lf[11:0], lf[15:4], lf[7:0], lf[15:12]};
      nf++;
      sv <= 1'b1;
      @(posedge i_clk);
      sv <= 1'b0;
      @(posedge i_clk);
    end
  endtask
  task automatic frame(input int f);
    for (int i = 2; i >= 0; i--) begin
      rd(8'h3f, {fr[f][12*i +: 4], 4'h0});
      rd(8'h3f, fr[f][12*i+4 +: 8]);
    end
  endtask
  task automatic hit(input axis_vec_t f, input axis_vec_t r);
    hf <= f;
    hr <= r;
    repeat (3) @(posedge i_clk);
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (rv === 1'b1) check("rsp", rdat, expq.pop_front());
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(8'h0c, 8'h00);
    rd(8'h01, 8'h00);
    for (int m = 0; m < 3; m++) begin
      wr(8'h3e, mc[m]);
      nf = 0;
      push(np[m]);
      rd(8'h0c, lv[m]);
      frame(ff[m]);
      rd(8'h0c, lv[m] - 8'h81);
    end
    push(1);
    wr(8'h3d, 8'h00);
    rd(8'h0c, 8'h00);
    wr(8'h20, 8'h03);
    wr(8'h17, 8'h80);
    wr(8'h19, 8'h04);
    push(1);
    rd(8'h0a, 8'h80);
    repeat (4) @(posedge i_clk);
    check("irq", {6'h0, ib, ia}, 8'h01);
    repeat (300) @(posedge i_clk);
    rd(8'h0a, 8'h00);
    wr(8'h38, 8'h01);
    push(1);
    rd(8'h38, 8'h01);
    push(1);
    check("acc", {ax[3:0], 4'h0},
      {4'(fr[nf-1][27:24] + 4'h8), 4'h0});
    rd(8'h3f, {4'(fr[nf-1][27:24] + 4'h8), 4'h0});
    wr(8'h36, 8'h80);
    rd(8'h38, 8'h00);
    wr(8'h16, 8'h01);
    wr(8'h2a, 8'h02);
    wr(8'h21, 8'h00);
    hit(3'h2, 3'h2);
    rd(8'h09, 8'h00);
    hit(3'h1, 3'h0);
    rd(8'h09, 8'h04);
    hit(3'h0, 3'h0);
    rd(8'h09, 8'h00);
    wr(8'h13, 8'h02);
    hit(3'h1, 3'h0);
    rd(8'h09, 8'h00);
    hit(3'h0, 3'h1);
    rd(8'h09, 8'h04);
    hit(3'h0, 3'h0);
    wr(8'h13, 8'h00);
    wr(8'h21, 8'h07);
    hit(3'h1, 3'h0);
    hit(3'h0, 3'h0);
    rd(8'h09, 8'h04);
    ack <= 1'b1;
    @(posedge i_clk);
    ack <= 1'b0;
    repeat (8) @(posedge i_clk);
    rd(8'h09, 8'h00);
    wr(8'h21, 8'h09);
    hit(3'h1, 3'h0);
    hit(3'h0, 3'h0);
    rd(8'h09, 8'h04);
    repeat (300) @(posedge i_clk);
    rd(8'h09, 8'h00);
    wr(8'h1a, 8'h01);
    wr(8'h3e, 8'h80);
    hit(3'h1, 3'h0);
    push(2);
    wr(8'h19, 8'h01);
    rd(8'h0c, 8'h81);
    push(2);
    rd(8'h0c, 8'h83);
    repeat (8) @(posedge i_clk);
    conclude();
  end
endmodule
`default_nettype wire
